/* File: hw/sfp_defines.vh */
// Constants shared by the serial frame controller: protocol codes, frame limits and FIFO shape.
// Assumes it is included by bare name from files under hw/ and tb/ and holds definitions only.
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

`define SFP_PROTO_SPI    2'h0
`define SFP_PROTO_CW     2'h1
`define SFP_PROTO_FP     2'h2
`define SFP_CW_CTRL_BITS 6'h08
`define SFP_CW_TURN_BIT  6'h08
`define SFP_MAX_FRAME    6'h20
`define SFP_DATA_W       32
`define SFP_FIFO_DEPTH   8
`define SFP_FIFO_AW      3
`define SFP_FCOUNT_W     8
`define SFP_DIV_W        8
`define SFP_SYNC_RESET   1'h0

`endif

/* File: hw/sfp_sync.v */
// Two-stage synchroniser for a group of independent single-bit levels.
// Assumes each bit is a slow level or clock from outside the REF clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_sync #(
   parameter W = 3
) (
   input  wire         clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   genvar g;
   // Each bit gets its own pair of flops; the first stage feeds only the second.
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge clk_i) begin
            if (!reset_n_i) begin
               meta   <= `SFP_SYNC_RESET;
               stable <= `SFP_SYNC_RESET;
            end else begin
               meta   <= async_i[g];
               stable <= meta;
            end
         end
         assign sync_o[g] = stable;
      end
   endgenerate
endmodule // sfp_sync
`default_nettype wire

/* File: hw/sfp_fifo.v */
// Synchronous FIFO with valid/ready on both sides, used in the transmit data path.
// Assumes one clock; a pop and a push may happen in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_fifo #(
   parameter W     = `SFP_DATA_W,
   parameter DEPTH = `SFP_FIFO_DEPTH,
   parameter AW    = `SFP_FIFO_AW
) (
   input  wire         clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] in_data_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   output wire [W-1:0] out_data_o,
   output wire         out_valid_o,
   input  wire         out_ready_i
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]   count;
   wire         push;
   wire         pop;

   // Full and empty come straight from the occupancy count, so back-pressure is exact.
   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;

   // Storage is written without reset; only pointers and count carry control state.
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers wrap at DEPTH, which is expected to be a power of two.
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count <= count + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count <= count - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // sfp_fifo
`default_nettype wire

/* File: hw/sfp_top.v */
// Serial frame controller: plain SPI, half-duplex control-word and frame-pulse framing.
// Assumes configuration ports are steady while busy and the serial clock is far slower than REF_CLK_I.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_top #(
   parameter DW         = `SFP_DATA_W,
   parameter FIFO_DEPTH = `SFP_FIFO_DEPTH,
   parameter DIV_W      = `SFP_DIV_W
) (
   input  wire                     REF_CLK_I,
   input  wire                     RESET_N_I,
   input  wire                     ENABLE_I,
   input  wire                     MASTER_I,
   input  wire [1:0]               PROTOCOL_I,
   input  wire                     CLOCK_POLARITY_BIT_I,
   input  wire                     CLOCK_PHASE_BIT_I,
   input  wire [5:0]               FRAME_SIZE_SETTING_I,
   input  wire [`SFP_FCOUNT_W-1:0] FRAME_COUNT_FIELD_I,
   input  wire [DIV_W-1:0]         CLK_DIV_I,
   input  wire [DW-1:0]            TX_DATA_I,
   input  wire                     TX_VALID_I,
   output wire                     TX_READY_O,
   output reg  [DW-1:0]            RX_DATA_O,
   output reg                      RX_VALID_O,
   input  wire                     RX_READY_I,
   output reg                      RX_OVERRUN_O,
   output wire                     BUSY_O,
   input  wire                     SCLK_I,
   output wire                     SCLK_O,
   output wire                     SCLK_OE_O,
   input  wire                     SELECT_I,
   output wire                     SELECT_O,
   input  wire                     DATA_I,
   output reg                      DATA_O,
   output reg                      DATA_OE_O,
   output reg                      OUTPUT_ENABLE_LINE_N_O
);
   localparam M_IDLE  = 3'h0;
   localparam M_SETUP = 3'h1;
   localparam M_SEL   = 3'h2;
   localparam M_BIT   = 3'h3;
   localparam M_WAIT  = 3'h4;
   localparam M_GAP   = 3'h5;
   localparam S_IDLE  = 2'h0;
   localparam S_ARMED = 2'h1;
   localparam S_RUN   = 2'h2;

   // Frame length clamped to 1..32; zero means the full 32 bits.
   function [5:0] fsize;
      input [5:0] sz;
      begin
         fsize = (sz == 6'h00 || sz > `SFP_MAX_FRAME) ? `SFP_MAX_FRAME : sz;
      end
   endfunction

   // Index of the final serial bit; control-word framing adds one turnaround bit.
   function [5:0] last_idx;
      input [5:0] sz;
      input [1:0] pr;
      begin
         last_idx = (pr == `SFP_PROTO_CW) ? fsize(sz) : fsize(sz) - 6'h01;
      end
   endfunction

   // Left-aligns a FIFO word so the first serial bit sits in bit 31.
   function [31:0] align;
      input [31:0] w;
      input [5:0]  sz;
      input [1:0]  pr;
      begin
         if (pr == `SFP_PROTO_CW) begin
            align = {w[31:24], 24'h000000};
         end else begin
            align = w << (6'h20 - fsize(sz));
         end
      end
   endfunction

   wire [2:0]    pins_s;
   wire          sclk_s;
   wire          ss_s;
   wire          din_s;
   wire [DW-1:0] fifo_data;
   wire          fifo_valid;
   wire          pop;
   wire          cpol_e;
   wire          cpha_e;
   wire          pat0;
   wire          sample_en;
   wire [5:0]    last;
   wire          slave_on;
   wire          fall;
   wire          rise;
   reg  [2:0]    m_state;
   reg           half;
   reg  [5:0]    bit_cnt;
   reg  [`SFP_FCOUNT_W-1:0] frames_left;
   reg  [31:0]   sh;
   reg  [31:0]   rx;
   reg  [31:0]   m_res;
   reg           m_done;
   reg           m_pop;
   reg           ss_m;
   reg           sclk_m;
   reg  [DIV_W-1:0] div_cnt;
   reg           tick;
   reg  [1:0]    s_state;
   reg  [5:0]    s_cnt;
   reg  [31:0]   s_sh;
   reg  [31:0]   s_rx;
   reg  [31:0]   s_res;
   reg           s_done;
   reg           s_pop;
   reg           sclk_d;
   reg           m_drive;
   reg           m_oen;

   // Pins from the far side pass two flops before anything looks at them.
   sfp_sync #(.W(3)) u_sync (
      .clk_i     (REF_CLK_I),
      .reset_n_i (RESET_N_I),
      .async_i   ({SCLK_I, SELECT_I, DATA_I}),
      .sync_o    (pins_s)
   );
   assign sclk_s = pins_s[2];
   assign ss_s   = pins_s[1];
   assign din_s  = pins_s[0];

   // Transmit words queue here; the serial engines pull one per frame.
   sfp_fifo #(.W(DW), .DEPTH(FIFO_DEPTH), .AW(`SFP_FIFO_AW)) u_txq (
      .clk_i       (REF_CLK_I),
      .reset_n_i   (RESET_N_I),
      .in_data_i   (TX_DATA_I),
      .in_valid_i  (TX_VALID_I),
      .in_ready_o  (TX_READY_O),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (pop)
   );
   assign pop = m_pop | s_pop;

   // Effective clock shape: frame-pulse drives on rising, captures on falling.
   assign cpol_e = (PROTOCOL_I == `SFP_PROTO_SPI) ? CLOCK_POLARITY_BIT_I : 1'b0;
   assign cpha_e = (PROTOCOL_I == `SFP_PROTO_SPI) ? CLOCK_PHASE_BIT_I :
                   (PROTOCOL_I == `SFP_PROTO_FP);
   assign pat0      = cpol_e ^ cpha_e;
   assign last      = last_idx(FRAME_SIZE_SETTING_I, PROTOCOL_I);
   assign sample_en = (PROTOCOL_I != `SFP_PROTO_CW) || (bit_cnt > `SFP_CW_TURN_BIT);
   assign slave_on  = ENABLE_I && !MASTER_I && (PROTOCOL_I == `SFP_PROTO_FP);
   assign fall      = sclk_d & ~sclk_s;
   assign rise      = ~sclk_d & sclk_s;
   assign SCLK_O    = sclk_m;
   assign SCLK_OE_O = ENABLE_I & MASTER_I;
   assign SELECT_O  = ss_m;
   assign BUSY_O    = (m_state != M_IDLE) || (s_state == S_RUN);

   // Half-period enable; held in reset while idle so the first half is always full length.
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I || m_state == M_IDLE) begin
         div_cnt <= {DIV_W{1'b0}};
         tick    <= 1'b0;
      end else if (div_cnt == CLK_DIV_I) begin
         div_cnt <= {DIV_W{1'b0}};
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
         tick    <= 1'b0;
      end
   end

   // Master engine. Each bit is two half periods: sample at the middle, shift at the end.
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         m_state     <= M_IDLE;
         half        <= 1'b0;
         bit_cnt     <= 6'h00;
         frames_left <= {`SFP_FCOUNT_W{1'b0}};
         sh          <= 32'h00000000;
         rx          <= 32'h00000000;
         m_res       <= 32'h00000000;
         m_done      <= 1'b0;
         m_pop       <= 1'b0;
         ss_m        <= 1'b1;
         sclk_m      <= 1'b0;
      end else begin
         m_pop  <= 1'b0;
         m_done <= 1'b0;
         case (m_state)
            M_IDLE: begin
               half    <= 1'b0;
               bit_cnt <= 6'h00;
               sclk_m  <= cpol_e;
               ss_m    <= (PROTOCOL_I != `SFP_PROTO_FP);
               if (ENABLE_I && MASTER_I && fifo_valid) begin
                  m_pop       <= 1'b1;
                  sh          <= align(fifo_data, FRAME_SIZE_SETTING_I, PROTOCOL_I);
                  rx          <= 32'h00000000;
                  frames_left <= FRAME_COUNT_FIELD_I;
                  if (PROTOCOL_I == `SFP_PROTO_FP) begin
                     ss_m    <= 1'b1;
                     sclk_m  <= pat0;
                     m_state <= M_SEL;
                  end else begin
                     ss_m    <= 1'b0;
                     m_state <= M_SETUP;
                  end
               end
            end
            M_SETUP: begin
               if (tick) begin
                  sclk_m  <= pat0;
                  m_state <= M_BIT;
               end
            end
            M_SEL: begin
               // One full clock with select high, then data starts on the next rising edge.
               if (tick) begin
                  half   <= ~half;
                  sclk_m <= half ? pat0 : ~pat0;
                  if (half) begin
                     ss_m    <= 1'b0;
                     m_state <= M_BIT;
                  end
               end
            end
            M_BIT: begin
               if (tick && !half) begin
                  half   <= 1'b1;
                  sclk_m <= ~pat0;
                  if (sample_en) begin
                     rx <= {rx[30:0], din_s};
                  end
               end else if (tick) begin
                  half   <= 1'b0;
                  sclk_m <= pat0;
                  if (bit_cnt != last) begin
                     bit_cnt <= bit_cnt + 6'h01;
                     sh      <= {sh[30:0], 1'b0};
                  end else begin
                     bit_cnt     <= 6'h00;
                     m_res       <= rx;
                     m_done      <= 1'b1;
                     frames_left <= (frames_left > 8'h01) ? frames_left - 8'h01 : 8'h00;
                     if (PROTOCOL_I == `SFP_PROTO_FP) begin
                        if (fifo_valid) begin
                           m_pop   <= 1'b1;
                           sh      <= align(fifo_data, FRAME_SIZE_SETTING_I, PROTOCOL_I);
                           rx      <= 32'h00000000;
                           ss_m    <= 1'b1;
                           m_state <= M_SEL;
                        end else begin
                           sclk_m  <= cpol_e;
                           m_state <= M_IDLE;
                        end
                     end else if (fifo_valid && (PROTOCOL_I == `SFP_PROTO_CW || cpha_e ||
                                                  frames_left > 8'h01)) begin
                        // Select stays low and the next frame follows at once.
                        m_pop <= 1'b1;
                        sh    <= align(fifo_data, FRAME_SIZE_SETTING_I, PROTOCOL_I);
                        rx    <= 32'h00000000;
                     end else if (PROTOCOL_I == `SFP_PROTO_SPI && frames_left > 8'h01) begin
                        // Counted transfer starved by the FIFO: hold select, park the clock.
                        sclk_m  <= cpol_e;
                        m_state <= M_WAIT;
                     end else begin
                        sclk_m  <= cpol_e;
                        ss_m    <= 1'b1;
                        m_state <= M_GAP;
                     end
                  end
               end
            end
            M_WAIT: begin
               if (fifo_valid) begin
                  m_pop   <= 1'b1;
                  sh      <= align(fifo_data, FRAME_SIZE_SETTING_I, PROTOCOL_I);
                  rx      <= 32'h00000000;
                  m_state <= M_SETUP;
               end
            end
            M_GAP: begin
               // Select high for one half period gives the slave a clean frame boundary.
               if (tick) begin
                  m_state <= M_IDLE;
               end
            end
            default: begin
               m_state <= M_IDLE;
            end
         endcase
      end
   end

   // Master pin enables: control-word framing drives only during the control byte.
   always @* begin
      m_drive = 1'b0;
      m_oen   = 1'b0;
      if (ENABLE_I && MASTER_I) begin
         case (PROTOCOL_I)
            `SFP_PROTO_CW: begin
               m_drive = (m_state == M_BIT) && (bit_cnt < `SFP_CW_CTRL_BITS);
               m_oen   = m_drive;
            end
            `SFP_PROTO_FP: begin
               m_drive = (m_state == M_BIT);
               m_oen   = (m_state != M_IDLE);
            end
            default: begin
               m_drive = (m_state != M_IDLE) && (m_state != M_GAP);
               m_oen   = m_drive;
            end
         endcase
      end
   end

   // Frame-pulse slave. Works only on seen clock edges, so a stopped clock simply freezes it.
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I || !slave_on) begin
         s_state <= S_IDLE;
         s_cnt   <= 6'h00;
         s_sh    <= 32'h00000000;
         s_rx    <= 32'h00000000;
         s_res   <= 32'h00000000;
         s_done  <= 1'b0;
         s_pop   <= 1'b0;
         sclk_d  <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         s_done <= 1'b0;
         s_pop  <= 1'b0;
         case (s_state)
            S_IDLE: begin
               if (fall && ss_s) begin
                  s_state <= S_ARMED;
               end
            end
            S_ARMED: begin
               if (rise) begin
                  s_pop   <= fifo_valid;
                  s_sh    <= fifo_valid ? align(fifo_data, FRAME_SIZE_SETTING_I, PROTOCOL_I) : 32'h00000000;
                  s_rx    <= 32'h00000000;
                  s_cnt   <= 6'h00;
                  s_state <= S_RUN;
               end
            end
            S_RUN: begin
               if (rise) begin
                  s_sh <= {s_sh[30:0], 1'b0};
               end
               if (fall) begin
                  s_rx <= {s_rx[30:0], din_s};
                  if (s_cnt == last) begin
                     s_res   <= {s_rx[30:0], din_s};
                     s_done  <= 1'b1;
                     s_state <= ss_s ? S_ARMED : S_IDLE;
                  end else begin
                     s_cnt <= s_cnt + 6'h01;
                  end
               end
            end
            default: begin
               s_state <= S_IDLE;
            end
         endcase
      end
   end

   // Pin outputs are registered to keep them glitch free.
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         DATA_O                 <= 1'b0;
         DATA_OE_O              <= 1'b0;
         OUTPUT_ENABLE_LINE_N_O <= 1'b1;
      end else begin
         DATA_O                 <= MASTER_I ? sh[31] : s_sh[31];
         DATA_OE_O              <= m_drive | (s_state == S_RUN);
         OUTPUT_ENABLE_LINE_N_O <= ~(m_oen | (s_state == S_RUN));
      end
   end

   // Receive holding word; a new frame replaces an unread one and flags the loss.
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         RX_DATA_O    <= {DW{1'b0}};
         RX_VALID_O   <= 1'b0;
         RX_OVERRUN_O <= 1'b0;
      end else if (m_done || s_done) begin
         RX_DATA_O    <= m_done ? m_res[DW-1:0] : s_res[DW-1:0];
         RX_VALID_O   <= 1'b1;
         RX_OVERRUN_O <= RX_VALID_O && !RX_READY_I;
      end else begin
         RX_OVERRUN_O <= 1'b0;
         if (RX_READY_I) begin
            RX_VALID_O <= 1'b0;
         end
      end
   end
endmodule // sfp_top
`default_nettype wire

/* File: tb/sfp_peer_model.sv */
// Behavioural far-side slave for control-word framing, answering on the data-in pin.
// Assumes master pins of the controller; the falling pad enable marks each control word.
`timescale 1ns/1ps
`default_nettype none
module sfp_peer_model (
   input  wire logic       sclk_i,
   input  wire logic       oe_n_i,
   input  wire logic       sel_i,
   input  wire logic       mosi_i,
   input  wire logic [7:0] resp_i,
   output var  logic       miso_o,
   output var  logic [7:0] ctl_o
);
   int cnt = 99;
   // Power-up line levels.
   initial miso_o = 1'b0;
   initial ctl_o = 8'h00;
   // A falling pad enable opens a new control word, even with select held low.
   always @(negedge oe_n_i) cnt = 0;
   // Control bits are taken on the rising serial edge.
   always @(posedge sclk_i) if (!sel_i && cnt < 8) ctl_o = {ctl_o[6:0], mosi_i};
   // One idle bit after the word, then an 8-bit reply MSB first; elsewhere the line keeps changing.
   always @(negedge sclk_i) begin
      cnt = cnt + 1;
      if (!sel_i && cnt >= 9 && cnt <= 16) miso_o = resp_i[16-cnt];
      else miso_o = ~miso_o;
   end
   // A released select must not leave a stale bit that looks like data.
   always @(posedge sel_i) miso_o = ~miso_o;
endmodule // sfp_peer_model
`default_nettype wire

/* File: tb/sfp_top_chk.sv */
// Concurrent checks on the serial frame controller's ports.
// Assumes one reference clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_top_chk #(
   parameter DW    = 32,
   parameter DIV_W = 8
) (
   input wire logic             REF_CLK_I,
   input wire logic             RESET_N_I,
   input wire logic             ENABLE_I,
   input wire logic             MASTER_I,
   input wire logic [1:0]       PROTOCOL_I,
   input wire logic [5:0]       FRAME_SIZE_SETTING_I,
   input wire logic [DIV_W-1:0] CLK_DIV_I,
   input wire logic [DW-1:0]    RX_DATA_O,
   input wire logic             RX_VALID_O,
   input wire logic             BUSY_O,
   input wire logic             SCLK_O,
   input wire logic             SELECT_O,
   input wire logic             DATA_O,
   input wire logic             DATA_OE_O,
   input wire logic             OUTPUT_ENABLE_LINE_N_O
);
   // Protocol qualifiers; configuration is static while a transfer runs.
   wire logic fp_m = MASTER_I && ENABLE_I && (PROTOCOL_I == `SFP_PROTO_FP);
   wire logic cw   = PROTOCOL_I == `SFP_PROTO_CW;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // Three idle cycles give the registered select pin time to settle.
   sequence s_fp_idle;
      (fp_m && !BUSY_O)[*3];
   endsequence
   // A control word holds the pad enable low for its whole span, then lets go.
   sequence s_cw_word;
      (!OUTPUT_ENABLE_LINE_N_O)[*8] ##[1:600] OUTPUT_ENABLE_LINE_N_O;
   endsequence
   property p_oe_busy; MASTER_I && DATA_OE_O |-> $past(BUSY_O); endproperty
   a_oe_busy: assert property (p_oe_busy) else $error("data pad driven out of frame");
   property p_fp_idle; s_fp_idle |-> !SELECT_O; endproperty
   a_fp_idle: assert property (p_fp_idle) else $error("idle select not low");
   property p_fp_oen; fp_m && DATA_OE_O |-> !OUTPUT_ENABLE_LINE_N_O; endproperty
   a_fp_oen: assert property (p_fp_oen) else $error("enable high during transfer");
   property p_fp_shift;
      fp_m && CLK_DIV_I != 0 && DATA_OE_O && $past(DATA_OE_O) && $changed(DATA_O) |-> SCLK_O;
   endproperty
   a_fp_shift: assert property (p_fp_shift) else $error("data moved on low clock");
   property p_cw_oe; cw && MASTER_I && !OUTPUT_ENABLE_LINE_N_O |-> DATA_OE_O; endproperty
   a_cw_oe: assert property (p_cw_oe) else $error("control byte not driven");
   property p_cw_word; cw && MASTER_I && CLK_DIV_I < 16 && $fell(OUTPUT_ENABLE_LINE_N_O) |-> s_cw_word; endproperty
   a_cw_word: assert property (p_cw_word) else $error("control word span wrong");
   property p_cw_rx;
      cw && RX_VALID_O && FRAME_SIZE_SETTING_I > 6'h08 && FRAME_SIZE_SETTING_I <= 6'h20
      |-> (RX_DATA_O >> (FRAME_SIZE_SETTING_I - 6'h08)) == '0;
   endproperty
   a_cw_rx: assert property (p_cw_rx) else $error("reply wider than payload");
   property p_rx_align;
      !cw && RX_VALID_O && FRAME_SIZE_SETTING_I != 6'h00 && FRAME_SIZE_SETTING_I < 6'h20
      |-> (RX_DATA_O >> FRAME_SIZE_SETTING_I) == '0;
   endproperty
   a_rx_align: assert property (p_rx_align) else $error("word wider than frame");
endmodule // sfp_top_chk
bind sfp_top sfp_top_chk #(.DW(DW), .DIV_W(DIV_W)) u_chk (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
   .ENABLE_I(ENABLE_I), .MASTER_I(MASTER_I), .PROTOCOL_I(PROTOCOL_I), .FRAME_SIZE_SETTING_I(FRAME_SIZE_SETTING_I),
   .CLK_DIV_I(CLK_DIV_I), .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O), .BUSY_O(BUSY_O), .SCLK_O(SCLK_O),
   .SELECT_O(SELECT_O), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .OUTPUT_ENABLE_LINE_N_O(OUTPUT_ENABLE_LINE_N_O));
`default_nettype wire

/* File: tb/sfp_top_tb.sv */
// Self-checking bench for the serial frame controller in master and slave roles.
// Assumes the controller with its FIFO and synchroniser, the far-side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_top_tb;
   logic        clk = 1'b0, rst_n = 1'b0, mst = 1'b1, cph = 1'b0, txv = 1'b0, rxr = 1'b1;
   logic        sclk_i = 1'b0, sel_i = 1'b0, sdin = 1'b0, sel_q = 1'b1, oen_q = 1'b1, so_bit;
   logic [1:0]  proto = 2'h0;
   logic [5:0]  fsz = 6'h08;
   logic [7:0]  fcnt = 8'h00;
   logic [31:0] txd = 32'h0, rx_word;
   logic [15:0] fpbits = 16'h0;
   wire logic [31:0] rxd;
   wire logic [7:0]  ctl;
   wire logic        txr, rxv, busy, sclk_o, sel_o, dout, doe, oen_n, miso, ovr, sclk_oe;
   int mismatches = 0, n_tests = 0, sel_rise = 0, oen_fall = 0, ovr_n = 0;
   // Half-period toggle gives the reference clock.
   always #2.5 clk = ~clk;
   sfp_top dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ENABLE_I(1'b1), .MASTER_I(mst), .PROTOCOL_I(proto),
      .CLOCK_POLARITY_BIT_I(cph), .CLOCK_PHASE_BIT_I(cph), .FRAME_SIZE_SETTING_I(fsz),
      .FRAME_COUNT_FIELD_I(fcnt), .CLK_DIV_I(8'h03), .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_READY_O(txr),
      .RX_DATA_O(rxd), .RX_VALID_O(rxv), .RX_READY_I(rxr), .RX_OVERRUN_O(ovr), .BUSY_O(busy), .SCLK_I(sclk_i),
      .SCLK_O(sclk_o), .SCLK_OE_O(sclk_oe), .SELECT_I(sel_i), .SELECT_O(sel_o), .DATA_I(mst ? miso : sdin),
      .DATA_O(dout), .DATA_OE_O(doe), .OUTPUT_ENABLE_LINE_N_O(oen_n));
   sfp_peer_model u_peer (.sclk_i(sclk_o), .oe_n_i(oen_n), .sel_i(sel_o), .mosi_i(dout), .resp_i(8'hA5),
      .miso_o(miso), .ctl_o(ctl));
   // Edge counters for select and pad enable, a high-cycle count for overrun, read before the edge's own updates land.
   always @(posedge clk) begin
      if (sel_o && !sel_q) sel_rise++;
      if (ovr) ovr_n++;
      if (!oen_n && oen_q) oen_fall++;
      sel_q = sel_o;
      oen_q = oen_n;
   end
   // Master data bits as a receiver sees them at the falling serial edge.
   always @(negedge sclk_o) if (doe) fpbits = {fpbits[14:0], dout};
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Configuration only changes while idle; select and enable counters restart once it has settled.
   task cfg(input logic [1:0] p, input logic m, input logic ph, input logic [5:0] s, input logic [7:0] c);
      proto = p;
      mst = m;
      cph = ph;
      fsz = s;
      fcnt = c;
      repeat (4) @(posedge clk);
      #1;
      sel_rise = 0;
      oen_fall = 0;
      fpbits = 16'h0;
   endtask
   // Valid is left high so pushes run back to back; the caller lowers it.
   task push(input logic [31:0] w);
      txd = w;
      txv = 1'b1;
      do @(posedge clk); while (txr !== 1'b1);
      #1;
   endtask
   task wait_idle;
      int k, q;
      k = 0;
      q = 0;
      while (q < 12 && k < 4000) begin
         @(posedge clk);
         q = (busy !== 1'b0) ? 0 : q + 1;
         k++;
      end
      if (k >= 4000) mismatches++;
      #1;
   endtask
   task wait_rx;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rxv !== 1'b1 && k < 4000);
      rx_word = (rxv === 1'b1) ? rxd : 'x;
      #1;
   endtask
   // One link clock period of 80 ns, ending with the clock low so it can stand still.
   task scyc(input logic s, input logic d);
      sclk_i = 1'b1;
      sel_i = s;
      sdin = d;
      #40;
      so_bit = dout;
      sclk_i = 1'b0;
      #40;
   endtask
   task t_spi(input logic ph, input logic [7:0] c, input int n, input int rises);
      cfg(`SFP_PROTO_SPI, 1'b1, ph, 6'h08, c);
      for (int i = 0; i < n; i++) push(32'h5A + i);
      txv = 1'b0;
      wait_idle;
      chk("select rises", sel_rise, rises);
      $display("test spi done");
   endtask
   task t_cw;
      cfg(`SFP_PROTO_CW, 1'b1, 1'b0, 6'h10, 8'h00);
      push(32'hC3FF_0F0F);
      push(32'h5A00_FFFF);
      txv = 1'b0;
      wait_rx;
      chk("cw reply 1", rx_word, 32'hA5);
      wait_rx;
      chk("cw reply 2", rx_word, 32'hA5);
      wait_idle;
      chk("control byte", ctl, 8'h5A);
      chk("cw select rises", sel_rise, 1);
      chk("cw enable pulses", oen_fall, 2);
      $display("test control word done");
   endtask
   // The receive side stalls here so one word waits and is then overwritten.
   task t_fp;
      rxr = 1'b0;
      cfg(`SFP_PROTO_FP, 1'b1, 1'b0, 6'h08, 8'h00);
      push(32'h96);
      push(32'h3C);
      txv = 1'b0;
      wait_idle;
      chk("fp bits", fpbits, 16'h963C);
      chk("fp select pulses", sel_rise, 2);
      chk("fp idle select", {sclk_oe, sel_o}, 2'b10);
      chk("fp pad released", doe, 1'b0);
      chk("fp overrun pulses", ovr_n, 1);
      rxr = 1'b1;
      $display("test frame pulse master done");
   endtask
   task t_slave;
      logic [7:0] pat, got;
      pat = 8'hB2;
      cfg(`SFP_PROTO_FP, 1'b0, 1'b0, 6'h08, 8'h00);
      push(32'h6D);
      txv = 1'b0;
      rxr = 1'b0;
      for (int i = 0; i < 4; i++) scyc(1'b0, ~sdin);
      chk("slave unarmed", {sclk_oe, busy, rxv}, 3'b000);
      scyc(1'b1, ~sdin);
      for (int i = 7; i >= 0; i--) begin
         scyc(i == 4, pat[i]);
         got[i] = so_bit;
         if (i == 5) #400;
      end
      wait_rx;
      chk("slave word", rx_word, 32'hB2);
      chk("slave sent", got, 8'h6D);
      $display("test frame pulse slave done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence: two cycles of reset, then each scenario in turn.
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      t_spi(1'b0, 8'h00, 2, 2);
      t_spi(1'b1, 8'h00, 3, 1);
      t_spi(1'b0, 8'h02, 2, 1);
      t_cw;
      t_fp;
      t_slave;
      report_and_stop;
   end
   // Watchdog well beyond the fewer than two thousand cycles the scenarios need.
   initial begin
      #200000;
      mismatches++;
      report_and_stop;
   end
endmodule // sfp_top_tb
`default_nettype wire
